/* File: rtl/pmbs_params.svh */
// constants for the power-mode and boot sequencer
// assumes nothing; definitions only
`ifndef PMBS_PARAMS_SVH
`define PMBS_PARAMS_SVH
`define PMBS_BOOT_SERIAL    1'h0
`define PMBS_BOOT_FLASH     1'h1
`define PMBS_SRAM_STEP_KB   8
`define PMBS_SRAM_MAX_KB    32
`define PMBS_SRAM_SEL_W     2
`define PMBS_SRAM_BANKS     4
`define PMBS_SRAM_BASE_MASK 4'h1
`define PMBS_EXT_WAKE_W     3
`define PMBS_RST_HOLD_NS    400
`define PMBS_CLK_PERIOD_NS  100
`define PMBS_RST_HOLD_CYC   ((`PMBS_RST_HOLD_NS + `PMBS_CLK_PERIOD_NS - 1) / `PMBS_CLK_PERIOD_NS)
`endif

/* File: rtl/pmbs_pkg.sv */
// types shared by the power-mode and boot sequencer
// assumes the constants header is included by users of numbers
package pmbs_pkg;
  typedef enum logic [1:0] {
    PMBS_MODE_ACTIVE,
    PMBS_MODE_CORE_GATED,
    PMBS_MODE_HIBERNATE,
    PMBS_MODE_SHUTDOWN
  } pmbs_mode_e;

  typedef struct packed {
    logic       ext_wake_irq_en;
    logic       serial_receive_wake_en;
    logic       seconds_clock_en;
    logic       fine_clock_en;
  } pmbs_wake_cfg_s;

  typedef struct packed {
    logic [2:0] ext_wake_irq;
    logic       serial_receive_wake;
    logic       seconds_clock;
    logic       fine_clock;
  } pmbs_wake_src_s;

  typedef struct packed {
    logic       pin_poweron;
    logic       pin_external;
    logic       watchdog_unit;
    logic       software;
  } pmbs_rst_cause_s;
endpackage

/* File: rtl/pmbs_sync.sv */
// three-stage synchroniser; a change counts once stages two and three agree
// assumes the input is asynchronous to i_clock
`timescale 1ns/1ps
module pmbs_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset and enable
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic             i_enable,
  // data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  initial begin
    if (WIDTH < 1) $error("pmbs_sync: WIDTH must be positive");
  end

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else if (i_enable) begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;
endmodule

/* File: rtl/pmbs_sequencer.sv */
// power-mode and boot sequencer: boot strap capture, mode control, wake, reset collection
// assumes a single 10 MHz clock; wake and strap pins are asynchronous, core requests are synchronous
//
// Summary of operation
// R1 - the boot select pin is caught after power-up or hard reset and a low level selects serial download.
// R2 - boot mode value 0 means serial download and value 1 means flash boot.
// R3 - in active mode every peripheral clock may be enabled under its own gating.
// R4 - in core-gated mode the core clock stops while system clocks and dma keep running.
// R5 - hibernate keeps logic state, selected sram and pin levels, and may keep both clocks running.
// R6 - hibernate wakes on an external interrupt, serial receive or either real-time clock event.
// R7 - shutdown powers everything down and wakes only on three external interrupts or the seconds clock.
// R8 - the seconds clock may stay enabled in shutdown so its event wakes the device periodically.
// R9 - pad levels are held in hibernate and shutdown, pad configuration is kept only in hibernate.
// R10 - after reset every general-purpose pin is high impedance until software configures it.
// R11 - a watchdog expiry that software failed to prevent becomes a system reset or an interrupt.
// R12 - hibernate sram retention is 8 to 32 kB in 8 kB steps, with the base 8 kB always kept.
// R13 - four reset sources are accepted: external pin, power-on, watchdog and software.
// R14 - the instruction cache is flagged invalid after waking from hibernate.
// R15 - the core requests low-power entry, and any enabled wake event returns the system to active, except serial receive and fine clock in shutdown.
`timescale 1ns/1ps
`include "pmbs_params.svh"
module pmbs_sequencer #(
  parameter int EXT_W    = `PMBS_EXT_WAKE_W,
  parameter int BANKS    = `PMBS_SRAM_BANKS,
  parameter int HOLD_CYC = `PMBS_RST_HOLD_CYC
) (
  // clock, reset, enable
  input  wire logic                     i_clock,
  input  wire logic                     i_resetn,
  input  wire logic                     i_clock_enable,
  // pins and reset requests
  input  wire logic                     i_boot_select_pin,
  input  wire logic                     i_hard_reset_pin,
  input  wire logic                     i_soft_reset_req,
  input  wire logic                     i_watchdog_expired,
  input  wire logic                     i_watchdog_irq_mode,
  // core mode requests
  input  wire logic                     i_req_valid,
  input  wire pmbs_pkg::pmbs_mode_e     i_req_mode,
  input  wire logic [`PMBS_SRAM_SEL_W-1:0] i_sram_keep_sel,
  input  wire logic                     i_pad_cfg_done,
  // wake sources and enables
  input  wire pmbs_pkg::pmbs_wake_src_s i_wake,
  input  wire pmbs_pkg::pmbs_wake_cfg_s i_wake_cfg,
  // status and controls
  output pmbs_pkg::pmbs_mode_e          o_mode,
  output logic                          o_boot_flash,
  output logic                          o_boot_done,
  output logic                          o_core_clk_en,
  output logic                          o_sys_clk_en,
  output logic                          o_periph_clk_allow,
  output logic                          o_logic_power_en,
  output logic                          o_analog_power_en,
  output logic                          o_state_retain,
  output logic [BANKS-1:0]              o_sram_retain,
  output logic                          o_pad_hold,
  output logic                          o_pad_cfg_keep,
  output logic                          o_gpio_tristate,
  output logic                          o_seconds_clock_run,
  output logic                          o_fine_clock_run,
  output logic                          o_icache_invalidate,
  output logic                          o_system_reset,
  output logic                          o_watchdog_irq,
  output pmbs_pkg::pmbs_rst_cause_s     o_reset_cause
);
  localparam int ASYNC_W = EXT_W + 5;

  initial begin
    if (EXT_W != `PMBS_EXT_WAKE_W) $error("pmbs_sequencer: EXT_W must match the three wake inputs");
    if (BANKS * `PMBS_SRAM_STEP_KB != `PMBS_SRAM_MAX_KB) $error("pmbs_sequencer: BANKS must cover 32 kB");
    if (HOLD_CYC < 1 || HOLD_CYC > 12) $error("pmbs_sequencer: HOLD_CYC must lie in 1 to 12");
  end

  // asynchronous pins go through the three-stage synchroniser
  logic [ASYNC_W-1:0] async_raw;
  logic [ASYNC_W-1:0] async_sync;
  assign async_raw = {i_boot_select_pin, i_hard_reset_pin, i_wake};

  pmbs_sync #(.WIDTH(ASYNC_W)) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_enable (i_clock_enable),
    .i_async  (async_raw),
    .o_sync   (async_sync)
  );

  logic                     boot_pin_s;
  logic                     hard_rst_s;
  pmbs_pkg::pmbs_wake_src_s wake_s;
  assign boot_pin_s = async_sync[ASYNC_W-1];
  assign hard_rst_s = async_sync[ASYNC_W-2];
  assign wake_s     = async_sync[ASYNC_W-3:0];

  // boot strap and reset collection
  logic [3:0]                 settle_reg;
  logic [3:0]                 settle_next;
  logic                       boot_done_reg;
  logic                       boot_done_next;
  logic                       boot_flash_reg;
  logic                       boot_flash_next;
  logic                       sys_rst_reg;
  logic                       sys_rst_next;
  logic                       wdt_irq_reg;
  logic                       wdt_irq_next;
  pmbs_pkg::pmbs_rst_cause_s  cause_reg;
  pmbs_pkg::pmbs_rst_cause_s  cause_next;
  logic                       rst_req;

  // settle counter covers the synchroniser latency before the strap is trusted
  always_comb begin
    settle_next     = settle_reg;
    boot_done_next  = boot_done_reg;
    boot_flash_next = boot_flash_reg;
    cause_next      = cause_reg;
    wdt_irq_next    = 1'b0;
    rst_req         = hard_rst_s || i_soft_reset_req || (i_watchdog_expired && !i_watchdog_irq_mode);
    sys_rst_next    = rst_req;
    if (rst_req) begin // [R13]
      settle_next    = 4'h0;
      boot_done_next = 1'b0;
      cause_next     = '{pin_poweron: 1'b0, pin_external: hard_rst_s,
                         watchdog_unit: i_watchdog_expired && !i_watchdog_irq_mode,
                         software: i_soft_reset_req};
    end else if (!boot_done_reg) begin
      if (settle_reg == 4'(HOLD_CYC + 3)) begin
        boot_done_next  = 1'b1;
        boot_flash_next = boot_pin_s ? `PMBS_BOOT_FLASH : `PMBS_BOOT_SERIAL; // [R1] [R2]
      end else begin
        settle_next = settle_reg + 4'h1;
      end
    end
    if (i_watchdog_expired && i_watchdog_irq_mode) begin
      wdt_irq_next = 1'b1; // [R11]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      settle_reg     <= 4'h0;
      boot_done_reg  <= 1'b0;
      boot_flash_reg <= `PMBS_BOOT_FLASH;
      sys_rst_reg    <= 1'b0;
      wdt_irq_reg    <= 1'b0;
      cause_reg      <= '{pin_poweron: 1'b1, default: 1'b0};
    end else if (i_clock_enable) begin
      settle_reg     <= settle_next;
      boot_done_reg  <= boot_done_next;
      boot_flash_reg <= boot_flash_next;
      sys_rst_reg    <= sys_rst_next;
      wdt_irq_reg    <= wdt_irq_next;
      cause_reg      <= cause_next;
    end
  end

  // mode state machine
  pmbs_pkg::pmbs_mode_e mode_reg;
  pmbs_pkg::pmbs_mode_e mode_next;
  logic [BANKS-1:0]     sram_reg;
  logic [BANKS-1:0]     sram_next;
  logic                 gpio_tri_reg;
  logic                 gpio_tri_next;
  logic                 icache_reg;
  logic                 icache_next;
  logic                 sec_run_reg;
  logic                 sec_run_next;
  logic                 fine_run_reg;
  logic                 fine_run_next;
  logic                 wake_hib;
  logic                 wake_sd;

  // wake terms only count enabled sources; the fine clock cannot reach shutdown
  assign wake_hib = (i_wake_cfg.ext_wake_irq_en && |wake_s.ext_wake_irq)
                 || (i_wake_cfg.serial_receive_wake_en && wake_s.serial_receive_wake)
                 || (i_wake_cfg.seconds_clock_en && wake_s.seconds_clock)
                 || (i_wake_cfg.fine_clock_en && wake_s.fine_clock);
  assign wake_sd  = (i_wake_cfg.ext_wake_irq_en && |wake_s.ext_wake_irq)
                 || (i_wake_cfg.seconds_clock_en && wake_s.seconds_clock);

  always_comb begin
    mode_next     = mode_reg;
    sram_next     = sram_reg;
    gpio_tri_next = gpio_tri_reg;
    icache_next   = 1'b0;
    sec_run_next  = sec_run_reg;
    fine_run_next = fine_run_reg;
    if (i_pad_cfg_done) begin
      gpio_tri_next = 1'b0;
    end
    case (mode_reg)
      pmbs_pkg::PMBS_MODE_ACTIVE, pmbs_pkg::PMBS_MODE_CORE_GATED: begin
        if (mode_reg == pmbs_pkg::PMBS_MODE_CORE_GATED && wake_hib) begin
          mode_next = pmbs_pkg::PMBS_MODE_ACTIVE; // [R15]
        end else if (i_req_valid && boot_done_reg) begin
          mode_next = i_req_mode; // [R15]
          if (i_req_mode == pmbs_pkg::PMBS_MODE_HIBERNATE) begin
            // base bank always kept, extra banks by selection [R12]
            for (int b = 0; b < BANKS; b++) begin
              sram_next[b] = (b <= int'(i_sram_keep_sel));
            end
          end
          sec_run_next  = i_wake_cfg.seconds_clock_en; // [R5] [R8]
          fine_run_next = i_wake_cfg.fine_clock_en && i_req_mode != pmbs_pkg::PMBS_MODE_SHUTDOWN;
        end
      end
      pmbs_pkg::PMBS_MODE_HIBERNATE: begin
        if (wake_hib) begin // [R6]
          mode_next   = pmbs_pkg::PMBS_MODE_ACTIVE;
          icache_next = 1'b1; // [R14]
        end
      end
      pmbs_pkg::PMBS_MODE_SHUTDOWN: begin
        if (wake_sd) begin // [R7]
          mode_next     = pmbs_pkg::PMBS_MODE_ACTIVE;
          icache_next   = 1'b1;
          gpio_tri_next = 1'b1; // configuration is lost [R9]
        end
      end
      default: mode_next = pmbs_pkg::PMBS_MODE_ACTIVE;
    endcase
    if (sys_rst_reg) begin
      mode_next     = pmbs_pkg::PMBS_MODE_ACTIVE;
      gpio_tri_next = 1'b1; // [R10]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_reg     <= pmbs_pkg::PMBS_MODE_ACTIVE;
      sram_reg     <= BANKS'(`PMBS_SRAM_BASE_MASK);
      gpio_tri_reg <= 1'b1;
      icache_reg   <= 1'b0;
      sec_run_reg  <= 1'b0;
      fine_run_reg <= 1'b0;
    end else if (i_clock_enable) begin
      mode_reg     <= mode_next;
      sram_reg     <= sram_next;
      gpio_tri_reg <= gpio_tri_next;
      icache_reg   <= icache_next;
      sec_run_reg  <= sec_run_next;
      fine_run_reg <= fine_run_next;
    end
  end

  // registered controls decoded from the mode; one cycle behind mode_reg
  logic [9:0] ctl_reg;
  logic [9:0] ctl_next;
  logic [BANKS-1:0] sram_out_reg;
  logic [BANKS-1:0] sram_out_next;
  always_comb begin
    case (mode_reg)
      pmbs_pkg::PMBS_MODE_ACTIVE:     ctl_next = 10'b1111000010; // [R3]
      pmbs_pkg::PMBS_MODE_CORE_GATED: ctl_next = 10'b0111000010; // [R4]
      pmbs_pkg::PMBS_MODE_HIBERNATE:  ctl_next = 10'b0000111110; // [R5] [R9]
      pmbs_pkg::PMBS_MODE_SHUTDOWN:   ctl_next = 10'b0000001000; // [R7] [R9]
      default:                        ctl_next = 10'b1111000010;
    endcase
    sram_out_next = ctl_next[4] ? sram_next : '0; // [R12]
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_reg      <= 10'b1111000010;
      sram_out_reg <= '0;
    end else if (i_clock_enable) begin
      ctl_reg      <= ctl_next;
      sram_out_reg <= sram_out_next;
    end
  end

  // bits: core, sys, periph, analog pwr, state, sram gate, pad hold, pad cfg, logic pwr
  assign o_mode              = mode_reg;
  assign o_boot_flash        = boot_flash_reg;
  assign o_boot_done         = boot_done_reg;
  assign o_core_clk_en       = ctl_reg[9];
  assign o_sys_clk_en        = ctl_reg[8];
  assign o_periph_clk_allow  = ctl_reg[7];
  assign o_logic_power_en    = ctl_reg[1];
  assign o_analog_power_en   = ctl_reg[6];
  assign o_state_retain      = ctl_reg[5];
  assign o_sram_retain       = sram_out_reg;
  assign o_pad_hold          = ctl_reg[3];
  assign o_pad_cfg_keep      = ctl_reg[2];
  assign o_gpio_tristate     = gpio_tri_reg;
  assign o_seconds_clock_run = sec_run_reg;
  assign o_fine_clock_run    = fine_run_reg;
  assign o_icache_invalidate = icache_reg;
  assign o_system_reset      = sys_rst_reg;
  assign o_watchdog_irq      = wdt_irq_reg;
  assign o_reset_cause       = cause_reg;

  // assertions
  property p_boot_low_serial;
    @(posedge i_clock) disable iff (!i_resetn)
      $rose(boot_done_reg) |-> boot_flash_reg == $past(boot_pin_s);
  endproperty
  a_boot_low_serial: assert property (p_boot_low_serial) else $error("boot mode not taken from strap"); // [R1]

  property p_boot_code;
    @(posedge i_clock) disable iff (!i_resetn)
      $rose(boot_done_reg) && !$past(boot_pin_s) |-> boot_flash_reg == 1'b0;
  endproperty
  a_boot_code: assert property (p_boot_code) else $error("low strap must give boot code 0"); // [R2]

  property p_active_clocks;
    @(posedge i_clock) disable iff (!i_resetn)
      i_clock_enable && mode_reg == pmbs_pkg::PMBS_MODE_ACTIVE ##1 i_clock_enable |-> o_core_clk_en && o_periph_clk_allow;
  endproperty
  a_active_clocks: assert property (p_active_clocks) else $error("active mode lost its clocks"); // [R3]

  property p_core_gated;
    @(posedge i_clock) disable iff (!i_resetn)
      i_clock_enable && mode_reg == pmbs_pkg::PMBS_MODE_CORE_GATED ##1 i_clock_enable |-> !o_core_clk_en && o_sys_clk_en;
  endproperty
  a_core_gated: assert property (p_core_gated) else $error("core-gated clocks wrong"); // [R4]

  property p_hib_wake;
    @(posedge i_clock) disable iff (!i_resetn)
      i_clock_enable && mode_reg == pmbs_pkg::PMBS_MODE_HIBERNATE && wake_hib && !sys_rst_reg
        |=> mode_reg == pmbs_pkg::PMBS_MODE_ACTIVE && o_icache_invalidate;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate did not wake"); // [R6] [R14]

  property p_sd_serial_ignored;
    @(posedge i_clock) disable iff (!i_resetn)
      mode_reg == pmbs_pkg::PMBS_MODE_SHUTDOWN && !wake_sd && !sys_rst_reg |=> mode_reg == pmbs_pkg::PMBS_MODE_SHUTDOWN;
  endproperty
  a_sd_serial_ignored: assert property (p_sd_serial_ignored) else $error("shutdown left without a legal wake"); // [R7]

  property p_sram_base;
    @(posedge i_clock) disable iff (!i_resetn)
      sram_reg[0];
  endproperty
  a_sram_base: assert property (p_sram_base) else $error("base sram bank not retained"); // [R12]

  property p_wdt_reset;
    @(posedge i_clock) disable iff (!i_resetn)
      i_clock_enable && i_watchdog_expired && !i_watchdog_irq_mode |=> o_system_reset ##1 !i_clock_enable || o_gpio_tristate;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog expiry gave no reset"); // [R11] [R10]
endmodule

/* File: tb/pmbs_core_model.sv */
// core and wake-source model: one-cycle mode requests and wake levels
// assumes the bench calls its tasks from code aligned to falling edges
`timescale 1ns/1ps
module pmbs_core_model (
  // clock and status
  input  wire logic                 i_clock,
  input  wire pmbs_pkg::pmbs_mode_e i_mode,
  // requests and wake lines
  output logic                      o_req_valid,
  output pmbs_pkg::pmbs_mode_e      o_req_mode,
  output pmbs_pkg::pmbs_wake_src_s  o_wake
);
  initial begin
    o_req_valid = 1'h0;
    o_req_mode  = pmbs_pkg::PMBS_MODE_ACTIVE;
    o_wake      = '0;
  end

  task automatic request(input pmbs_pkg::pmbs_mode_e mode);
    @(negedge i_clock);
    o_req_valid = 1'h1;
    o_req_mode  = mode;
    @(negedge i_clock);
    o_req_valid = 1'h0;
    // idle code differs from the last one so a stale mode is never reused
    o_req_mode  = pmbs_pkg::pmbs_mode_e'(~mode);
  endtask

  // wake level stands until the block is active again or the limit runs out
  task automatic wake(input pmbs_pkg::pmbs_wake_src_s src, input int limit, output logic ok);
    int n;
    n = 0;
    @(negedge i_clock);
    o_wake = src;
    while (i_mode !== pmbs_pkg::PMBS_MODE_ACTIVE && n < limit) begin
      @(negedge i_clock);
      n++;
    end
    ok     = (i_mode === pmbs_pkg::PMBS_MODE_ACTIVE);
    o_wake = '0;
    // the synchronised level lingers; let it drain so it cannot wake the next mode
    repeat (5) @(negedge i_clock);
  endtask
endmodule

/* File: tb/pmbs_sequencer_tb_top.sv */
// self-checking bench for the power-mode and boot sequencer
// assumes a 10 MHz clock; inputs change on falling edges only
`timescale 1ns/1ps
`include "pmbs_params.svh"
module pmbs_sequencer_tb_top;
  logic                            i_clock = 1'h0;
  logic                            i_resetn = 1'h0;
  logic                            clk_en = 1'h1;
  logic                            boot_sel = 1'h1;
  logic                            hard_rst = 1'h0;
  logic                            soft_rst = 1'h0;
  logic                            wd_exp = 1'h0;
  logic                            wd_irq_mode = 1'h0;
  logic                            req_valid;
  pmbs_pkg::pmbs_mode_e            req_mode;
  logic [`PMBS_SRAM_SEL_W-1:0]     sram_sel = '0;
  logic                            pad_done = 1'h0;
  pmbs_pkg::pmbs_wake_src_s        wake;
  pmbs_pkg::pmbs_wake_cfg_s        wcfg = 4'hf;
  pmbs_pkg::pmbs_mode_e            o_mode;
  pmbs_pkg::pmbs_rst_cause_s       o_cause;
  logic [3:0]                      o_sram;
  logic                            o_flash, o_done, o_core, o_sys, o_periph, o_logic, o_analog, o_state;
  logic                            o_hold, o_keep, o_tri, o_sec, o_fine, o_icache, o_sysrst, o_wdirq;
  int                              err_count = 0;
  int                              checks = 0;
  int                              cycles = 0;
  int                              ic_cnt = 0;
  logic                            ok;

  pmbs_sequencer pmbs_sequencer_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_clock_enable(clk_en),
    .i_boot_select_pin(boot_sel), .i_hard_reset_pin(hard_rst), .i_soft_reset_req(soft_rst),
    .i_watchdog_expired(wd_exp), .i_watchdog_irq_mode(wd_irq_mode), .i_req_valid(req_valid),
    .i_req_mode(req_mode), .i_sram_keep_sel(sram_sel), .i_pad_cfg_done(pad_done), .i_wake(wake),
    .i_wake_cfg(wcfg), .o_mode(o_mode), .o_boot_flash(o_flash), .o_boot_done(o_done),
    .o_core_clk_en(o_core), .o_sys_clk_en(o_sys), .o_periph_clk_allow(o_periph),
    .o_logic_power_en(o_logic), .o_analog_power_en(o_analog), .o_state_retain(o_state),
    .o_sram_retain(o_sram), .o_pad_hold(o_hold), .o_pad_cfg_keep(o_keep), .o_gpio_tristate(o_tri),
    .o_seconds_clock_run(o_sec), .o_fine_clock_run(o_fine), .o_icache_invalidate(o_icache),
    .o_system_reset(o_sysrst), .o_watchdog_irq(o_wdirq), .o_reset_cause(o_cause)
  );

  pmbs_core_model pmbs_core_model_inst (
    .i_clock(i_clock), .i_mode(o_mode), .o_req_valid(req_valid), .o_req_mode(req_mode), .o_wake(wake)
  );

  always #50 i_clock = ~i_clock;

  // one-cycle pulse is sampled well after the edge that launches it
  always @(posedge i_clock) begin
    #10;
    if (o_icache === 1'h1) begin
      ic_cnt++;
    end
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_boot();
    int n;
    n = 0;
    repeat (3) @(negedge i_clock);
    while (o_done !== 1'h1 && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    chk(o_done, 1'h1);
  endtask

  task automatic t_boot();
    @(negedge i_clock);
    chk(o_tri, 1'h1);
    chk(o_cause, 4'h8);
    wait_boot();
    chk(o_flash, 1'h1);
    chk(o_periph, 1'h1);
    pad_done = 1'h1;
    @(negedge i_clock);
    pad_done = 1'h0;
    @(negedge i_clock);
    chk(o_tri, 1'h0);
  endtask

  task automatic t_freeze();
    clk_en = 1'h0;
    pmbs_core_model_inst.request(pmbs_pkg::PMBS_MODE_CORE_GATED);
    chk(o_mode, pmbs_pkg::PMBS_MODE_ACTIVE);
    chk(o_core, 1'h1);
    clk_en = 1'h1;
    @(negedge i_clock);
    chk(o_mode, pmbs_pkg::PMBS_MODE_ACTIVE);
  endtask

  task automatic t_core_gated();
    pmbs_core_model_inst.request(pmbs_pkg::PMBS_MODE_CORE_GATED);
    chk(o_mode, pmbs_pkg::PMBS_MODE_CORE_GATED);
    @(negedge i_clock);
    chk(o_core, 1'h0);
    chk(o_sys, 1'h1);
    pmbs_core_model_inst.wake(6'h04, 20, ok);
    chk(ok, 1'h1);
    @(negedge i_clock);
    chk(o_core, 1'h1);
  endtask

  task automatic t_hibernate();
    pmbs_pkg::pmbs_wake_src_s srcs[4];
    int ic0;
    srcs = '{6'h20, 6'h04, 6'h02, 6'h01};
    for (int s = 0; s < 4; s++) begin
      sram_sel = s[1:0];
      pmbs_core_model_inst.request(pmbs_pkg::PMBS_MODE_HIBERNATE);
      chk(o_mode, pmbs_pkg::PMBS_MODE_HIBERNATE);
      @(negedge i_clock);
      chk(o_sram, 8'((1 << (s + 1)) - 1));
      chk({o_state, o_hold, o_keep, o_sec, o_fine}, 5'h1f);
      chk({o_core, o_sys, o_periph, o_analog}, 4'h0);
      ic0 = ic_cnt;
      pmbs_core_model_inst.wake(srcs[s], 20, ok);
      chk(ok, 1'h1);
      @(negedge i_clock);
      chk(ic_cnt - ic0, 8'h01);
      chk({o_core, o_hold, o_tri}, 3'h4);
    end
  endtask

  task automatic t_shutdown(input logic sec_en);
    wcfg.seconds_clock_en = sec_en;
    pmbs_core_model_inst.request(pmbs_pkg::PMBS_MODE_SHUTDOWN);
    @(negedge i_clock);
    chk({o_logic, o_analog, o_hold, o_keep}, 4'h2);
    chk({o_sec, o_fine}, {sec_en, 1'h0});
    pmbs_core_model_inst.wake(6'h04, 12, ok);
    chk(ok, 1'h0);
    pmbs_core_model_inst.wake(6'h01, 12, ok);
    chk(ok, 1'h0);
    pmbs_core_model_inst.wake(6'h02, 12, ok);
    chk(ok, sec_en);
    if (!sec_en) begin
      pmbs_core_model_inst.wake(6'h08, 12, ok);
      chk(ok, 1'h1);
    end
    @(negedge i_clock);
    chk(o_tri, 1'h1);
    wcfg.seconds_clock_en = 1'h1;
  endtask

  task automatic t_resets();
    wd_irq_mode = 1'h1;
    wd_exp = 1'h1;
    @(negedge i_clock);
    wd_exp = 1'h0;
    chk({o_wdirq, o_sysrst}, 2'h2);
    wd_irq_mode = 1'h0;
    wd_exp = 1'h1;
    @(negedge i_clock);
    wd_exp = 1'h0;
    chk({o_sysrst, o_cause.watchdog_unit}, 2'h3);
    wait_boot();
    soft_rst = 1'h1;
    @(negedge i_clock);
    soft_rst = 1'h0;
    chk({o_sysrst, o_cause.software}, 2'h3);
    wait_boot();
    boot_sel = 1'h0;
    hard_rst = 1'h1;
    repeat (8) @(negedge i_clock);
    chk({o_sysrst, o_cause.pin_external}, 2'h3);
    hard_rst = 1'h0;
    wait_boot();
    chk(o_flash, 1'h0);
  endtask

  initial begin
    repeat (16) @(negedge i_clock);
    i_resetn = 1'h1;
    t_boot();
    t_freeze();
    t_core_gated();
    t_hibernate();
    t_shutdown(1'h1);
    t_shutdown(1'h0);
    t_resets();
    final_report();
  end
endmodule
